//--- eips_consts.vh
// Purpose : Constants for the external pin interrupt sense block
// Assumes : Included by the design and by the bench
// Notes   : Offsets are register indexes; byte address is four times the index
`ifndef EIPS_CONSTS_VH
`define EIPS_CONSTS_VH

// ************************************************************
// Register indexes (byte address = index * 4)
// ************************************************************
`define EIPS_IDX_PIN_LOW_SENSE   4'h0
`define EIPS_IDX_PIN_HIGH_SENSE  4'h1
`define EIPS_IDX_PORT_SENSE_A    4'h2
`define EIPS_IDX_PIN_PENDING     4'h3
`define EIPS_IDX_PORT_PENDING    4'h4
`define EIPS_IDX_PORT_SENSE_B    4'hA
`define EIPS_IDX_NIBBLE_ROUTE    4'hC
`define EIPS_IDX_IRQ_MASK        4'hD

// ************************************************************
// Reset values
// ************************************************************
`define EIPS_RST_SENSE           8'h00
`define EIPS_RST_SENSE_B         4'h0
`define EIPS_RST_PIN_PENDING     8'h00
`define EIPS_RST_PORT_PENDING    6'h00
`define EIPS_RST_ROUTE           12'h000
`define EIPS_RST_MASK            14'h0000

// ************************************************************
// Sensitivity field encodings
// ************************************************************
`define EIPS_SENSE_FALL_LOW      2'h0
`define EIPS_SENSE_RISE          2'h1
`define EIPS_SENSE_FALL          2'h2
`define EIPS_SENSE_BOTH          2'h3

// ************************************************************
// Field layout and bus answers
// ************************************************************
`define EIPS_LINE_MASK_FULL      6'h3F
`define EIPS_LINE_MASK_MEDIUM    6'h0F
`define EIPS_RESP_OKAY           2'h0
`define EIPS_RESP_SLVERR         2'h2

`endif

//--- eips_top.v
// Purpose : Pin interrupt sensitivity, pending flags and AXI4-Lite registers
// Assumes : Pins and priority bits synchronous-ish to clk_sys_i; one clock
// Notes   : Per-flag requests go to the priority controller; irq_o is masked OR
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`include "eips_consts.vh"

module eips_top #(
   parameter HAS_PORTS_GH = 1          // 1 = larger variant with ports G and H
) (
   input  wire        clk_sys_i,
   input  wire        rst_n_i,
   // Pins of ports A..H, port A in bits 7:0
   input  wire [63:0] port_pins_i,
   // Pin is an input with interrupt enabled (from port config)
   input  wire [63:0] pin_int_en_i,
   // Processor software priority bits
   input  wire        priority_bit_high_i,
   input  wire        priority_bit_low_i,
   // AXI4-Lite slave
   input  wire [7:0]  s_axi_awaddr_i,
   input  wire        s_axi_awvalid_i,
   output wire        s_axi_awready_o,
   input  wire [31:0] s_axi_wdata_i,
   input  wire [3:0]  s_axi_wstrb_i,
   input  wire        s_axi_wvalid_i,
   output wire        s_axi_wready_o,
   output wire [1:0]  s_axi_bresp_o,
   output wire        s_axi_bvalid_o,
   input  wire        s_axi_bready_i,
   input  wire [7:0]  s_axi_araddr_i,
   input  wire        s_axi_arvalid_i,
   output wire        s_axi_arready_o,
   output wire [31:0] s_axi_rdata_o,
   output wire [1:0]  s_axi_rresp_o,
   output wire        s_axi_rvalid_o,
   input  wire        s_axi_rready_i,
   // Requests toward the priority controller
   output wire [7:0]  position_irq_o,
   output wire [5:0]  port_line_irq_o,
   output wire        irq_o
);

   // ************************************************************
   // Reset synchroniser
   // ************************************************************
   reg         rst_meta_reg;           // First stage, read only by second
   reg         rst_sync_n_reg;         // Released reset for the block

   // Async assert, release after two edges
   always @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_reg   <= 1'b0;
         rst_sync_n_reg <= 1'b0;
      end else begin
         rst_meta_reg   <= 1'b1;
         rst_sync_n_reg <= rst_meta_reg;
      end
   end

   // ************************************************************
   // Registers
   // ************************************************************
   reg  [7:0]  pin_low_sense_ctrl_reg;   // pos3..pos0 sense
   reg  [7:0]  pin_high_sense_ctrl_reg;  // pos7..pos4 sense
   reg  [7:0]  port_sense_ctrl_a_reg;    // F,E,D,B line sense
   reg  [3:0]  port_sense_ctrl_b_reg;    // H,G line sense
   reg  [7:0]  pin_pending_flags_reg;    // Position pending flags
   reg  [5:0]  port_pending_flags_reg;   // Whole-port pending flags
   reg  [11:0] nibble_route_reg;         // {H,G,F,E,D,B} x {hi,lo}
   reg  [13:0] irq_mask_reg;             // {port flags, pin flags}
   reg         irq_reg;                  // Combined interrupt level

   // Larger variant keeps G and H, medium masks them off
   wire [5:0]  line_avail = (HAS_PORTS_GH != 0) ? `EIPS_LINE_MASK_FULL : `EIPS_LINE_MASK_MEDIUM;

   // Sense writes unlocked only at level three
   wire        level3 = priority_bit_high_i & priority_bit_low_i;

   // ************************************************************
   // Pin synchroniser and previous sample
   // ************************************************************
   reg  [63:0] pin_meta_reg;           // First stage, read only by second
   reg  [63:0] pin_sync_reg;           // Current synchronised sample
   reg  [63:0] pin_prev_reg;           // Previous synchronised sample

   // Two-flop sync plus history; idle high so a low pin at release reads as a falling edge
   always @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         pin_meta_reg <= 64'hFFFFFFFFFFFFFFFF;
         pin_sync_reg <= 64'hFFFFFFFFFFFFFFFF;
         pin_prev_reg <= 64'hFFFFFFFFFFFFFFFF;
      end else begin
         pin_meta_reg <= port_pins_i;
         pin_sync_reg <= pin_meta_reg;
         pin_prev_reg <= pin_sync_reg;
      end
   end

   // ************************************************************
   // Event detection per pin
   // ************************************************************
   // Sense decode of one field
   function eips_hit;
      input [1:0] mode;
      input       prev;
      input       cur;
      begin
         case (mode)
            `EIPS_SENSE_FALL_LOW: eips_hit = ~cur;
            `EIPS_SENSE_RISE:     eips_hit = ~prev & cur;
            `EIPS_SENSE_FALL:     eips_hit = prev & ~cur;
            default:              eips_hit = prev ^ cur;
         endcase
      end
   endfunction

   wire [15:0] pos_mode_all  = {pin_high_sense_ctrl_reg, pin_low_sense_ctrl_reg};
   wire [15:0] line_mode_all = {4'h0, port_sense_ctrl_b_reg, port_sense_ctrl_a_reg};
   wire [15:0] route_all     = {4'h0, nibble_route_reg};
   wire [63:0] pos_hit;                // Pin event on its position line
   wire [63:0] line_hit;               // Pin event on its whole-port line
   genvar gi;
   generate
      for (gi = 0; gi < 64; gi = gi + 1) begin : g_pin
         // Port A=0..H=7, bit position in the port
         localparam PORT = gi / 8;
         localparam POS  = gi % 8;
         // Whole-port line index, 7 means no line (ports A and C)
         localparam LIDX = (PORT == 1) ? 0 : (PORT == 3) ? 1 : (PORT == 4) ? 2 :
                           (PORT == 5) ? 3 : (PORT == 6) ? 4 : (PORT == 7) ? 5 : 7;
         // Position line covers A-E, and F only at position 0
         localparam POS_OK = (PORT <= 4) || ((PORT == 5) && (POS == 0)) ? 1 : 0;
         wire routed = route_all[2 * LIDX + POS / 4];
         wire en     = pin_int_en_i[gi];
         wire pos_ev = eips_hit(pos_mode_all[2 * POS +: 2], pin_prev_reg[gi], pin_sync_reg[gi]);
         wire ln_ev  = eips_hit(line_mode_all[2 * LIDX +: 2], pin_prev_reg[gi], pin_sync_reg[gi]);
         assign pos_hit[gi]  = (POS_OK != 0) & en & ~routed & pos_ev;
         assign line_hit[gi] = en & routed & ln_ev;
      end
   endgenerate

   reg  [7:0]  pos_event;              // Event per position line
   reg  [5:0]  line_event;             // Event per whole-port line
   integer     k;
   // OR all contributing pins onto each line
   always @* begin
      pos_event  = 8'h00;
      for (k = 0; k < 64; k = k + 1) begin
         pos_event[k % 8] = pos_event[k % 8] | pos_hit[k];
      end
      // Whole-port lines {H,G,F,E,D,B}; the medium variant drops G and H
      line_event = {|line_hit[63:56], |line_hit[55:48], |line_hit[47:40],
                    |line_hit[39:32], |line_hit[31:24], |line_hit[15:8]} & line_avail;
   end

   // ************************************************************
   // AXI4-Lite slave
   // ************************************************************
   reg         awready_reg;            // Write address slot free
   reg         wready_reg;             // Write data slot free
   reg  [3:0]  waddr_idx_reg;          // Latched write index
   reg         waddr_ok_reg;           // Latched write address in map range
   reg  [31:0] wdata_reg;              // Latched write data
   reg  [3:0]  wstrb_reg;              // Latched byte strobes
   reg         bvalid_reg;             // Write answer pending
   reg  [1:0]  bresp_reg;              // Write answer code
   reg         arready_reg;            // Read address slot free
   reg         rvalid_reg;             // Read answer pending
   reg  [31:0] rdata_reg;              // Read answer data
   reg  [1:0]  rresp_reg;              // Read answer code

   wire aw_take = s_axi_awvalid_i & awready_reg;
   wire w_take  = s_axi_wvalid_i & wready_reg;
   // Both halves held and no answer outstanding
   wire wr_go   = ~awready_reg & ~wready_reg & ~bvalid_reg;
   wire ar_take = s_axi_arvalid_i & arready_reg;

   // Decode of the latched write index
   reg         wr_hit;                 // Index maps to a register
   always @* begin
      if (!waddr_ok_reg) begin
         wr_hit = 1'b0;
      end else if ((waddr_idx_reg == `EIPS_IDX_PIN_LOW_SENSE) || (waddr_idx_reg == `EIPS_IDX_PIN_HIGH_SENSE) ||
                   (waddr_idx_reg == `EIPS_IDX_PORT_SENSE_A) || (waddr_idx_reg == `EIPS_IDX_PIN_PENDING) ||
                   (waddr_idx_reg == `EIPS_IDX_PORT_PENDING) || (waddr_idx_reg == `EIPS_IDX_PORT_SENSE_B) ||
                   (waddr_idx_reg == `EIPS_IDX_NIBBLE_ROUTE) || (waddr_idx_reg == `EIPS_IDX_IRQ_MASK)) begin
         wr_hit = 1'b1;
      end else begin
         wr_hit = 1'b0;                  // Unmapped index
      end
   end

   // Single write strobe per register, byte lane 0 for 8-bit fields
   wire       wr_en  = wr_go & wr_hit;
   wire       lane0  = wstrb_reg[0];
   wire       lane1  = wstrb_reg[1];
   wire       wr_sel_low   = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PIN_LOW_SENSE);
   wire       wr_sel_high  = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PIN_HIGH_SENSE);
   wire       wr_sel_pa    = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PORT_SENSE_A);
   wire       wr_sel_pb    = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PORT_SENSE_B) & (HAS_PORTS_GH != 0);
   wire       wr_sel_pinf  = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PIN_PENDING);
   wire       wr_sel_portf = wr_en & lane0 & (waddr_idx_reg == `EIPS_IDX_PORT_PENDING);
   wire       wr_sel_route = wr_en & (waddr_idx_reg == `EIPS_IDX_NIBBLE_ROUTE);
   wire       wr_sel_mask  = wr_en & (waddr_idx_reg == `EIPS_IDX_IRQ_MASK);

   // Write channel handshakes and answer
   always @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         awready_reg   <= 1'b1;
         wready_reg    <= 1'b1;
         waddr_idx_reg <= 4'h0;
         waddr_ok_reg  <= 1'b0;
         wdata_reg     <= 32'h00000000;
         wstrb_reg     <= 4'h0;
         bvalid_reg    <= 1'b0;
         bresp_reg     <= `EIPS_RESP_OKAY;
      end else begin
         // Address and data taken in either order
         if (aw_take) begin
            awready_reg   <= 1'b0;
            waddr_idx_reg <= s_axi_awaddr_i[5:2];
            waddr_ok_reg  <= (s_axi_awaddr_i[7:6] == 2'h0);
         end
         if (w_take) begin
            wready_reg <= 1'b0;
            wdata_reg  <= s_axi_wdata_i;
            wstrb_reg  <= s_axi_wstrb_i;
         end
         // Answer once both halves are in; unmapped gets SLVERR
         if (wr_go) begin
            bvalid_reg <= 1'b1;
            bresp_reg  <= wr_hit ? `EIPS_RESP_OKAY : `EIPS_RESP_SLVERR;
         end else if (bvalid_reg & s_axi_bready_i) begin
            bvalid_reg  <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg  <= 1'b1;
         end
      end
   end

   // Read multiplexer, narrow data in low bits, rest zero
   reg  [31:0] rd_mux;
   reg         rd_hit;
   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = (s_axi_araddr_i[7:6] == 2'h0);
      if (s_axi_araddr_i[5:2] == `EIPS_IDX_PIN_LOW_SENSE) begin
         rd_mux[7:0] = pin_low_sense_ctrl_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_PIN_HIGH_SENSE) begin
         rd_mux[7:0] = pin_high_sense_ctrl_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_PORT_SENSE_A) begin
         rd_mux[7:0] = port_sense_ctrl_a_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_PIN_PENDING) begin
         rd_mux[7:0] = pin_pending_flags_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_PORT_PENDING) begin
         rd_mux[5:0] = port_pending_flags_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_PORT_SENSE_B) begin
         rd_mux[3:0] = port_sense_ctrl_b_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_NIBBLE_ROUTE) begin
         rd_mux[11:0] = nibble_route_reg;
      end else if (s_axi_araddr_i[5:2] == `EIPS_IDX_IRQ_MASK) begin
         rd_mux[13:0] = irq_mask_reg;
      end else begin
         rd_hit = 1'b0;                                 // Unmapped index
      end
   end

   // Read channel: one outstanding read
   always @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         arready_reg <= 1'b1;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h00000000;
         rresp_reg   <= `EIPS_RESP_OKAY;
      end else if (ar_take) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b1;
         rdata_reg   <= rd_hit ? rd_mux : 32'h00000000;
         rresp_reg   <= rd_hit ? `EIPS_RESP_OKAY : `EIPS_RESP_SLVERR;
      end else if (rvalid_reg & s_axi_rready_i) begin
         rvalid_reg  <= 1'b0;
         arready_reg <= 1'b1;
      end
   end

   // ************************************************************
   // Control and status register update
   // ************************************************************
   wire [7:0] pin_clr  = wr_sel_pinf  ? wdata_reg[7:0] : 8'h00;
   wire [5:0] port_clr = wr_sel_portf ? wdata_reg[5:0] : 6'h00;

   // Sense writes dropped unless level three; events win over clears
   always @(posedge clk_sys_i or negedge rst_sync_n_reg) begin
      if (!rst_sync_n_reg) begin
         pin_low_sense_ctrl_reg  <= `EIPS_RST_SENSE;
         pin_high_sense_ctrl_reg <= `EIPS_RST_SENSE;
         port_sense_ctrl_a_reg   <= `EIPS_RST_SENSE;
         port_sense_ctrl_b_reg   <= `EIPS_RST_SENSE_B;
         pin_pending_flags_reg   <= `EIPS_RST_PIN_PENDING;
         port_pending_flags_reg  <= `EIPS_RST_PORT_PENDING;
         nibble_route_reg        <= `EIPS_RST_ROUTE;
         irq_mask_reg            <= `EIPS_RST_MASK;
         irq_reg                 <= 1'b0;
      end else begin
         if (wr_sel_low & level3) begin
            pin_low_sense_ctrl_reg <= wdata_reg[7:0];
         end
         if (wr_sel_high & level3) begin
            pin_high_sense_ctrl_reg <= wdata_reg[7:0];
         end
         if (wr_sel_pa & level3) begin
            port_sense_ctrl_a_reg <= wdata_reg[7:0];
         end
         if (wr_sel_pb & level3) begin
            port_sense_ctrl_b_reg <= wdata_reg[3:0];
         end
         // Route and mask bits, byte lanes honoured
         if (wr_sel_route) begin
            nibble_route_reg <= {lane1 ? wdata_reg[11:8] : nibble_route_reg[11:8],
                                 lane0 ? wdata_reg[7:0] : nibble_route_reg[7:0]};
         end
         if (wr_sel_mask) begin
            irq_mask_reg <= {lane1 ? wdata_reg[13:8] : irq_mask_reg[13:8],
                             lane0 ? wdata_reg[7:0] : irq_mask_reg[7:0]};
         end
         // Sticky flags: set wins over a same-cycle clear
         pin_pending_flags_reg  <= (pin_pending_flags_reg & ~pin_clr) | pos_event;
         port_pending_flags_reg <= ((port_pending_flags_reg & ~port_clr) | line_event) & line_avail;
         // Masked level, one cycle behind the flags
         irq_reg <= |({port_pending_flags_reg, pin_pending_flags_reg} & irq_mask_reg);
      end
   end

   // ************************************************************
   // Outputs
   // ************************************************************
   assign s_axi_awready_o = awready_reg;
   assign s_axi_wready_o  = wready_reg;
   assign s_axi_bvalid_o  = bvalid_reg;
   assign s_axi_bresp_o   = bresp_reg;
   assign s_axi_arready_o = arready_reg;
   assign s_axi_rvalid_o  = rvalid_reg;
   assign s_axi_rdata_o   = rdata_reg;
   assign s_axi_rresp_o   = rresp_reg;
   assign position_irq_o  = pin_pending_flags_reg;
   assign port_line_irq_o = port_pending_flags_reg;
   assign irq_o           = irq_reg;

endmodule // eips_top

//--- eips_checker.sv
// Purpose : Port timing checks for the pin interrupt sense block
// Assumes : One clock domain; sees eips_top ports only
// Notes   : Bus latencies follow the slave's registered handshakes
`timescale 1ns/1ps
module eips_checker (
   input wire logic       clk_sys_i,
   input wire logic       rst_n_i,
   input wire logic       s_axi_awvalid_i,
   input wire logic       s_axi_awready_o,
   input wire logic       s_axi_wvalid_i,
   input wire logic       s_axi_wready_o,
   input wire logic       s_axi_bvalid_o,
   input wire logic       s_axi_bready_i,
   input wire logic       s_axi_arvalid_i,
   input wire logic       s_axi_arready_o,
   input wire logic       s_axi_rvalid_o,
   input wire logic       s_axi_rready_i,
   input wire logic [7:0] position_irq_o,
   input wire logic [5:0] port_line_irq_o,
   input wire logic       irq_o
);
   // *****
   // Clocking and handshake sequences
   // *****
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!rst_n_i);
   // Address and data taken at one edge
   sequence s_wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   // One busy cycle, then the response
   sequence s_wr_answer;
      !s_axi_awready_o ##1 s_axi_bvalid_o;
   endsequence
   AST_WR_ANSWER: assert property (s_wr_take |=> s_wr_answer)
      else $error("write response not two cycles after take");
   AST_RD_ANSWER: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o)
      else $error("read data not one cycle after address");
   AST_B_BUSY: assert property ($rose(s_axi_bvalid_o) |-> !s_axi_awready_o && !s_axi_wready_o)
      else $error("write channels ready during response");
   AST_B_DONE: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o && s_axi_awready_o)
      else $error("write response not retired");
   AST_R_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
      else $error("read data not retired");
   AST_POS_CLEAR: assert property (|($past(position_irq_o) & ~position_irq_o) |-> $rose(s_axi_bvalid_o))
      else $error("position flag dropped without a write");
   AST_LINE_CLEAR: assert property (|($past(port_line_irq_o) & ~port_line_irq_o) |-> $rose(s_axi_bvalid_o))
      else $error("port flag dropped without a write");
   AST_IRQ_SOURCE: assert property (irq_o |-> $past(|{position_irq_o, port_line_irq_o}))
      else $error("interrupt without a pending flag");
endmodule // eips_checker

bind eips_top eips_checker eips_checker_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
   .s_axi_awvalid_i(s_axi_awvalid_i), .s_axi_awready_o(s_axi_awready_o), .s_axi_wvalid_i(s_axi_wvalid_i),
   .s_axi_wready_o(s_axi_wready_o), .s_axi_bvalid_o(s_axi_bvalid_o), .s_axi_bready_i(s_axi_bready_i),
   .s_axi_arvalid_i(s_axi_arvalid_i), .s_axi_arready_o(s_axi_arready_o), .s_axi_rvalid_o(s_axi_rvalid_o),
   .s_axi_rready_i(s_axi_rready_i), .position_irq_o(position_irq_o), .port_line_irq_o(port_line_irq_o),
   .irq_o(irq_o));

//--- eips_pin_model.sv
// Purpose : Far-side model of the external port pins
// Assumes : Bench sets wanted levels; pins move just after an edge
// Notes   : Pins are plain levels, never released
`timescale 1ns/1ps
module eips_pin_model (
   input  wire logic        clk_sys_i,
   input  wire logic [63:0] pin_set_i,
   input  wire logic [63:0] en_set_i,
   output logic      [63:0] port_pins_o,
   output logic      [63:0] pin_int_en_o
);
   // *****
   // Pin drive
   // *****
   // Registered so no change ever lands on the sampling edge
   always @(posedge clk_sys_i) begin
      port_pins_o  <= pin_set_i;
      pin_int_en_o <= en_set_i;
   end
endmodule // eips_pin_model

//--- external_pin_interrupt_sense_bench.sv
// Purpose : Self-checking bench for the pin interrupt sense block
// Assumes : 250 MHz clock; registers at byte address index*4
// Notes   : Flag waits are 8 cycles, well above the 3-cycle sync path
`timescale 1ns/1ps
`include "eips_consts.vh"
module external_pin_interrupt_sense_bench;
   logic        clk_sys_i, rst_n_i, pri_hi, pri_lo;
   logic [7:0]  awaddr, araddr;
   logic [31:0] wdata;
   logic        awvalid, wvalid, bready, arvalid, rready;
   logic [63:0] pin_set, en_set;
   wire  [63:0] pins, pin_en;
   wire         awready, wready, bvalid, arready, rvalid, irq;
   wire  [1:0]  bresp, rresp;
   wire  [31:0] rdata;
   wire  [7:0]  pos_irq;
   wire  [5:0]  line_irq;
   int          n_fail, compares;
   eips_pin_model eips_pin_model_inst (.clk_sys_i(clk_sys_i),
      .pin_set_i(pin_set), .en_set_i(en_set), .port_pins_o(pins), .pin_int_en_o(pin_en));
   eips_top eips_top_inst (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .port_pins_i(pins),
      .pin_int_en_i(pin_en), .priority_bit_high_i(pri_hi), .priority_bit_low_i(pri_lo),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
      .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
      .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .position_irq_o(pos_irq),
      .port_line_irq_o(line_irq), .irq_o(irq));
   initial begin
      clk_sys_i = 1'b0;
      forever #2 clk_sys_i = ~clk_sys_i;
   end
   // *****
   // Reporting and bus tasks
   // *****
   task automatic print_verdict();
      $display("compares=%0d mismatches=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Ready sampled at the falling edge, where it is settled
   task automatic wr(input logic [3:0] idx, input logic [7:0] d, input logic [1:0] er);
      int   n;
      logic a, w, b;
      n = 0;
      @(posedge clk_sys_i);
      awaddr  <= {2'h0, idx, 2'h0};
      wdata   <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do begin
         @(negedge clk_sys_i);
         a = awready;
         w = wready;
         b = bvalid;
         if (b === 1'b1) chk({30'h0, bresp}, {30'h0, er});
         @(posedge clk_sys_i);
         if (a === 1'b1) awvalid <= 1'b0;
         if (w === 1'b1) wvalid <= 1'b0;
         n++;
      end while (b !== 1'b1 && n < 64);
      bready <= 1'b0;
      if (b !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
   endtask
   task automatic rd(input logic [3:0] idx, input logic [7:0] ed, input logic [1:0] er);
      int   n;
      logic a, r;
      n = 0;
      @(posedge clk_sys_i);
      araddr  <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do begin
         @(negedge clk_sys_i);
         a = arready;
         r = rvalid;
         if (r === 1'b1) begin
            chk(rdata, {24'h0, ed});
            chk({30'h0, rresp}, {30'h0, er});
         end
         @(posedge clk_sys_i);
         if (a === 1'b1) arvalid <= 1'b0;
         n++;
      end while (r !== 1'b1 && n < 64);
      rready <= 1'b0;
      if (r !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
   endtask
   // Moves one pin, then lets the sync path settle
   task automatic pin(input int i, input logic v);
      @(posedge clk_sys_i);
      pin_set[i] <= v;
      repeat (8) @(posedge clk_sys_i);
   endtask
   // *****
   // Scenarios
   // *****
   task automatic t_reset();
      for (int i = 0; i < 14; i++) begin
         if (i < 5 || i == 10 || i > 11) rd(i[3:0], 8'h00, `EIPS_RESP_OKAY);
      end
      rd(4'h5, 8'h00, `EIPS_RESP_SLVERR);
      wr(4'h7, 8'hFF, `EIPS_RESP_SLVERR);
      $display("t_reset done");
   endtask
   task automatic t_lock();
      for (int p = 0; p < 3; p++) begin
         @(posedge clk_sys_i);
         {pri_hi, pri_lo} <= p[1:0];
         wr(4'h0, 8'hFF, `EIPS_RESP_OKAY);
         rd(4'h0, 8'h00, `EIPS_RESP_OKAY);
      end
      @(posedge clk_sys_i);
      {pri_hi, pri_lo} <= 2'b11;
      wr(4'h0, 8'hA5, `EIPS_RESP_OKAY);
      rd(4'h0, 8'hA5, `EIPS_RESP_OKAY);
      wr(4'h1, 8'h5A, `EIPS_RESP_OKAY);
      rd(4'h1, 8'h5A, `EIPS_RESP_OKAY);
      wr(4'h2, 8'hC3, `EIPS_RESP_OKAY);
      rd(4'h2, 8'hC3, `EIPS_RESP_OKAY);
      wr(4'hA, 8'hFF, `EIPS_RESP_OKAY);
      rd(4'hA, 8'h0F, `EIPS_RESP_OKAY);
      $display("t_lock done");
   endtask
   // Every mode on position 1, fall first, then rise
   task automatic t_modes();
      for (int m = 0; m < 4; m++) begin
         wr(4'h0, {4'h0, m[1:0], 2'h0}, `EIPS_RESP_OKAY);
         pin(1, 1'b0);
         rd(4'h3, (m == 1) ? 8'h00 : 8'h02, `EIPS_RESP_OKAY);
         pin(1, 1'b1);
         rd(4'h3, 8'h02, `EIPS_RESP_OKAY);
         @(negedge clk_sys_i);
         chk({24'h0, pos_irq}, 32'h2);
         wr(4'h3, 8'h02, `EIPS_RESP_OKAY);
         rd(4'h3, 8'h00, `EIPS_RESP_OKAY);
      end
      $display("t_modes done");
   endtask
   // Port B bit 4 per position, then routed to its whole-port line
   task automatic t_route();
      pin(12, 1'b0);
      rd(4'h3, 8'h10, `EIPS_RESP_OKAY);
      pin(12, 1'b1);
      wr(4'h3, 8'h10, `EIPS_RESP_OKAY);
      wr(4'hC, 8'h02, `EIPS_RESP_OKAY);
      pin(12, 1'b0);
      rd(4'h3, 8'h00, `EIPS_RESP_OKAY);
      rd(4'h4, 8'h01, `EIPS_RESP_OKAY);
      @(negedge clk_sys_i);
      chk({26'h0, line_irq}, 32'h1);
      pin(12, 1'b1);
      wr(4'h4, 8'h01, `EIPS_RESP_OKAY);
      rd(4'h4, 8'h00, `EIPS_RESP_OKAY);
      pin(41, 1'b0);
      pin(40, 1'b0);
      pin(40, 1'b1);
      rd(4'h3, 8'h01, `EIPS_RESP_OKAY);
      wr(4'h3, 8'h01, `EIPS_RESP_OKAY);
      @(posedge clk_sys_i);
      en_set[2] <= 1'b0;
      pin(2, 1'b0);
      rd(4'h3, 8'h00, `EIPS_RESP_OKAY);
      pin(2, 1'b1);
      $display("t_route done");
   endtask
   task automatic t_irq();
      pin(1, 1'b0);
      @(negedge clk_sys_i);
      chk({31'h0, irq}, 32'h0);
      wr(4'hD, 8'h02, `EIPS_RESP_OKAY);
      rd(4'hD, 8'h02, `EIPS_RESP_OKAY);
      @(negedge clk_sys_i);
      chk({31'h0, irq}, 32'h1);
      wr(4'h3, 8'h02, `EIPS_RESP_OKAY);
      @(negedge clk_sys_i);
      chk({31'h0, irq}, 32'h0);
      $display("t_irq done");
   endtask
   initial begin
      rst_n_i = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready, pri_hi, pri_lo} = '0;
      {awaddr, araddr, wdata} = '0;
      pin_set = '1;
      en_set = '1;
      n_fail = 0;
      compares = 0;
      repeat (4) @(posedge clk_sys_i);
      rst_n_i <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      t_reset();
      t_lock();
      t_modes();
      t_route();
      t_irq();
      print_verdict();
   end
endmodule // external_pin_interrupt_sense_bench
